// ===== cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic go_stop_i,
    input  wire logic go_wait_i,
    input  wire logic irq_req_i,
    input  wire logic core_run_i,
    output logic      stop_mode_o,
    output logic      wait_mode_o,
    output logic      irq_accept_o
);
    // ----------------------------------------
    // Instruction decode and interrupt acceptance
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stop_mode_o  <= 1'b0;
            wait_mode_o  <= 1'b0;
            irq_accept_o <= 1'b0;
        end else begin
            stop_mode_o  <= go_stop_i;
            wait_mode_o  <= go_wait_i;
            // Wake source enabled above current level before standby, so it is taken
            // Held until the core clock returns: the controller may sit in a wake delay
            irq_accept_o <= irq_req_i & ~core_run_i;
        end
    end
endmodule // cpu_model

`default_nettype wire

// ===== standby_ctrl.sv
// What this block does
// - Stop halts oscillator and PLL, holds clocks low, exit dividers high.
// - Entering stop loads the twelve-bit watchdog count with all ones.
// - On stop exit the watchdog counts on a divide clock picked by two bits.
// - In stop the converter and watchdog halt; timers event-only, serial external-only.
// - Interrupt or reset ends stop; oscillator, PLL, input/system/peripheral clocks resume.
// - Reset exit restores bus and core clocks at once; reset held past settling.
// - Internal clock or PLL selected: wait for watchdog top bit zero, then resume.
// - External clock without PLL: resume on first falling edge of divide clock.
// - Wait, clock-stop clear: only bus/core clocks, watchdog dividers and watchdog stop.
// - Wait, clock-stop set: system and peripheral clocks stop too.
// - Interrupt acceptance ends wait and resumes bus and core clocks at once.
// - Bus fixation hands bus pins to port control during stop or wait.
// - Fixation applies only in stop or wait; pins return when mode ends.
// - Address, data, strobes and chip select each map to a fixed port group.
// - Eight-bit bus leaves upper data and high-byte write strobe to ports always.
// - External clock stops the oscillator driver; PLL disabled stays stopped.
// - Stop-disable bit makes stop ignored; reset clears it.
// - Stop or wait sets an executed flag; software clears it afterwards.
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.svh"

module standby_ctrl
    import standby_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic        stop_mode_i,
    input  wire logic        wait_mode_i,
    input  wire logic        irq_accept_i,
    input  wire logic        byte_bus_i,
    output logic             osc_run_o,
    output logic             osc_driver_off_o,
    output logic             pll_run_o,
    output logic             input_clock_en_o,
    output logic             sys_clock_en_o,
    output logic             peripheral_clocks_en_o,
    output logic             watchdog_div_en_o,
    output logic             bus_unit_clock_en_o,
    output logic             stop_exit_hold_o,
    output logic             adc_run_o,
    output logic             watchdog_run_o,
    output logic             timer_event_only_o,
    output logic             serial_ext_only_o,
    output logic [6:0]       port_mux_o
);

    sb_state_t   s;
    sb_state_t   n;
    logic [11:0] wake_count;
    logic        wake_load;
    logic        exit_tick;

    // ----------------------------------------
    // Watchdog wake delay counter
    // ----------------------------------------
    wake_timer u_wake (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .load_i  (wake_load),
        .tick_i  (exit_tick),
        .run_i   (s.mode == ST_WCNT),
        .count_o (wake_count)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic req;
        logic wr;
        logic exit_lvl;
        logic fix;
        logic stby;
        logic [31:0] rd;
        req = 1'b0;
        wr = 1'b0;
        exit_lvl = 1'b1;
        fix = 1'b0;
        stby = 1'b0;
        rd = 32'h0000_0000;
        n = s;

        // Pin strap for bus width: accepted once stages two and three agree
        n.sync = {s.sync[1:0], byte_bus_i};
        if (s.sync[1] == s.sync[2]) begin
            n.byte_bus = s.sync[2];
        end

        // Stop-exit divider is frozen high in stop so the first edge after
        // wake-up is a clean falling one
        if (s.mode == ST_STOP) begin
            exit_lvl = 1'b1;
        end else begin
            n.div = s.div + 7'h01;
            exit_lvl = s.div[`EXIT_DIV_BASE + 32'(s.exit_src)];
        end
        n.exit_prev = exit_lvl;
        exit_tick = s.exit_prev && !exit_lvl;

        // Wishbone classic slave, one wait state
        req = cyc_i && stb_i && !s.ack;
        wr = req && we_i && sel_i[0];
        n.ack = req;

        if (wr) begin
            unique case (adr_i)
                `OFS_FUNC0: begin
                    n.stop_dis = dat_i[`F0_STOP_DIS];
                    n.ext_clk = dat_i[`F0_EXT_CLK];
                end
                `OFS_FUNC1: begin
                    // Writing zero clears an executed flag, writing one keeps it
                    n.stop_done = s.stop_done && dat_i[`F1_STOP_DONE];
                    n.wait_done = s.wait_done && dat_i[`F1_WAIT_DONE];
                    n.bus_fix = dat_i[`F1_BUS_FIX];
                    n.wait_cstop = dat_i[`F1_WAIT_CSTOP];
                end
                `OFS_CLKCTL: begin
                    n.pll_en = dat_i[`CC_PLL_EN];
                    // PLL output can only be picked while the PLL is enabled
                    n.sys_sel = dat_i[`CC_SYS_SEL] && dat_i[`CC_PLL_EN];
                end
                `OFS_WDTFS: begin
                    n.exit_src = dat_i[`WF_SRC_LO +: 2];
                end
                default: begin
                end
            endcase
        end
        if (!n.pll_en) begin
            n.sys_sel = 1'b0;
        end

        // Mode sequencing
        wake_load = 1'b0;
        unique case (s.mode)
            ST_RUN: begin
                if (stop_mode_i && !s.stop_dis) begin
                    n.mode = ST_STOP;
                    n.stop_done = 1'b1;
                    wake_load = 1'b1;
                end else if (wait_mode_i) begin
                    n.mode = ST_WAIT;
                    n.wait_done = 1'b1;
                end
                // A stop request with stop disabled falls through unseen
            end
            ST_STOP: begin
                if (irq_accept_i) begin
                    if (!s.ext_clk || s.sys_sel) begin
                        n.mode = ST_WCNT;
                    end else begin
                        n.mode = ST_WEDGE;
                    end
                end
            end
            ST_WCNT: begin
                if (!wake_count[11]) begin
                    n.mode = ST_RUN;
                end
            end
            ST_WEDGE: begin
                if (exit_tick) begin
                    n.mode = ST_RUN;
                end
            end
            ST_WAIT: begin
                if (irq_accept_i) begin
                    n.mode = ST_RUN;
                end
            end
            default: begin
                n.mode = ST_RUN;
            end
        endcase

        // Clock gate levels: all registered so the downstream gating cells
        // see one clean change per mode step, never a runt
        stby = n.mode == ST_STOP || n.mode == ST_WAIT;
        n.osc_run = n.mode != ST_STOP && !n.ext_clk;
        n.osc_drv_off = n.ext_clk;
        n.pll_run = n.mode != ST_STOP && n.pll_en;
        n.in_clk_en = n.mode != ST_STOP;
        n.sys_clk_en = !(n.mode == ST_STOP || (n.mode == ST_WAIT && n.wait_cstop));
        n.peri_en = n.sys_clk_en;
        n.wdiv_en = !stby;
        n.bus_en = n.mode == ST_RUN;
        n.div_hold = n.mode == ST_STOP;
        n.adc_run = n.sys_clk_en;
        n.wdt_run = !stby;
        n.evt_only = !n.sys_clk_en;
        n.ser_ext = !n.sys_clk_en;

        // Bus pin hand-over
        fix = stby && n.bus_fix;
        n.port_mux[`PM_ADDR] = fix; // address to ports ten, eleven, zero
        n.port_mux[`PM_DLO] = fix; // low data to port one
        n.port_mux[`PM_DHI] = fix || n.byte_bus; // port two
        n.port_mux[`PM_RD] = fix; // port three bit one
        n.port_mux[`PM_LBW] = fix; // port three bit two
        n.port_mux[`PM_HBW] = fix || n.byte_bus; // port three bit three
        n.port_mux[`PM_CS0] = fix; // port nine bit zero

        // Read data reflects state before this cycle's write
        unique case (adr_i)
            `OFS_FUNC0: begin
                rd[`F0_STOP_DIS] = s.stop_dis;
                rd[`F0_EXT_CLK] = s.ext_clk;
            end
            `OFS_FUNC1: begin
                rd[`F1_STOP_DONE] = s.stop_done;
                rd[`F1_WAIT_DONE] = s.wait_done;
                rd[`F1_BUS_FIX] = s.bus_fix;
                rd[`F1_WAIT_CSTOP] = s.wait_cstop;
            end
            `OFS_CLKCTL: begin
                rd[`CC_PLL_EN] = s.pll_en;
                rd[`CC_SYS_SEL] = s.sys_sel;
            end
            `OFS_WDTFS: begin
                rd[`WF_SRC_LO +: 2] = s.exit_src;
            end
            `OFS_STATUS: begin
                rd[2:0] = s.mode;
                rd[`ST_BYTE_BUS] = s.byte_bus;
                rd[`ST_COUNT_LO +: 12] = wake_count;
            end
            default: begin
            end
        endcase
        n.rdat = req ? rd : 32'h0000_0000;
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // Reset is also the reset exit from stop: bus clocks run at once
            s <= '0;
            s.mode <= ST_RUN;
            s.stop_dis <= 1'b0;
            s.pll_en <= `PLL_EN_RST;
            s.osc_run <= 1'b1;
            s.pll_run <= `PLL_EN_RST;
            s.in_clk_en <= 1'b1;
            s.sys_clk_en <= 1'b1;
            s.peri_en <= 1'b1;
            s.wdiv_en <= 1'b1;
            s.bus_en <= 1'b1;
            s.adc_run <= 1'b1;
            s.wdt_run <= 1'b1;
        end else if (ce_i) begin
            s <= n;
        end
    end

    assign dat_o = s.rdat;
    assign ack_o = s.ack;
    assign osc_run_o = s.osc_run;
    assign osc_driver_off_o = s.osc_drv_off;
    assign pll_run_o = s.pll_run;
    assign input_clock_en_o = s.in_clk_en;
    assign sys_clock_en_o = s.sys_clk_en;
    assign peripheral_clocks_en_o = s.peri_en;
    assign watchdog_div_en_o = s.wdiv_en;
    assign bus_unit_clock_en_o = s.bus_en;
    assign stop_exit_hold_o = s.div_hold;
    assign adc_run_o = s.adc_run;
    assign watchdog_run_o = s.wdt_run;
    assign timer_event_only_o = s.evt_only;
    assign serial_ext_only_o = s.ser_ext;
    assign port_mux_o = s.port_mux;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_stop_gates_held: assert property (@(posedge clk_i) disable iff (rst_i)
        s.mode == ST_STOP |-> !osc_run_o && !pll_run_o && !sys_clock_en_o
            && !bus_unit_clock_en_o && !watchdog_div_en_o && stop_exit_hold_o)
        else $error("stop mode clock levels wrong");

    a_stop_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.mode == ST_RUN && stop_mode_i && s.stop_dis |=> s.mode != ST_STOP)
        else $error("stop taken while disabled");

    a_count_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.mode == ST_WCNT && !wake_count[11] |=> s.mode == ST_RUN && bus_unit_clock_en_o)
        else $error("wake count exit missed");

    a_count_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        s.mode == ST_WCNT && wake_count[11] |=> !bus_unit_clock_en_o)
        else $error("bus clock before count ended");

    a_edge_wake: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.mode == ST_WEDGE && exit_tick |=> bus_unit_clock_en_o)
        else $error("edge wake missed");

    a_wait_exit: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.mode == ST_WAIT && irq_accept_i |=> s.mode == ST_RUN && bus_unit_clock_en_o)
        else $error("wait exit missed");

    a_wait_periph: assert property (@(posedge clk_i) disable iff (rst_i)
        s.mode == ST_WAIT |-> sys_clock_en_o == !s.wait_cstop && !watchdog_run_o)
        else $error("wait clock levels wrong");

    a_fix_window: assert property (@(posedge clk_i) disable iff (rst_i)
        port_mux_o[`PM_ADDR] |-> (s.mode == ST_STOP || s.mode == ST_WAIT) && s.bus_fix)
        else $error("bus fixation outside standby");

    a_fix_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        (s.mode == ST_STOP || s.mode == ST_WAIT) && s.bus_fix |-> port_mux_o == 7'h7F)
        else $error("bus pins not handed to ports");

    a_byte_bus_hi: assert property (@(posedge clk_i) disable iff (rst_i)
        s.byte_bus |-> port_mux_o[`PM_DHI] && port_mux_o[`PM_HBW])
        else $error("upper data not on port");

    a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && s.mode == ST_RUN && stop_mode_i && !s.stop_dis |=> s.stop_done ##1 s.mode != ST_RUN)
        else $error("stop flag not set");

    a_pll_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !s.pll_en |-> !pll_run_o && !s.sys_sel)
        else $error("pll runs while disabled");

endmodule // standby_ctrl

`default_nettype wire

// ===== standby_defines.svh
`ifndef STANDBY_DEFINES_SVH
`define STANDBY_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_FUNC0      5'h00
`define OFS_FUNC1      5'h04
`define OFS_CLKCTL     5'h08
`define OFS_WDTFS      5'h0C
`define OFS_STATUS     5'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define F0_STOP_DIS    0
`define F0_EXT_CLK     1
`define F1_STOP_DONE   0
`define F1_WAIT_DONE   1
`define F1_BUS_FIX     2
`define F1_WAIT_CSTOP  3
`define CC_PLL_EN      1
`define CC_SYS_SEL     5
`define WF_SRC_LO      6
`define ST_COUNT_LO    8
`define ST_BYTE_BUS    3

// ----------------------------------------
// Pin hand-over vector positions
// ----------------------------------------
`define PM_ADDR        0
`define PM_DLO         1
`define PM_DHI         2
`define PM_RD          3
`define PM_LBW         4
`define PM_HBW         5
`define PM_CS0         6

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define PLL_EN_RST     1'b1
`define WDT_LOAD       12'hFFF
`define EXIT_DIV_BASE  3

`endif

// ===== standby_pkg.sv
package standby_pkg;

    typedef enum logic [2:0] {
        ST_RUN   = 3'h0,
        ST_STOP  = 3'h1,
        ST_WCNT  = 3'h3,
        ST_WEDGE = 3'h2,
        ST_WAIT  = 3'h6
    } mode_t;

    typedef struct packed {
        logic [11:0] cnt;
    } wake_state_t;

    typedef struct packed {
        mode_t       mode;
        logic        ack;
        logic [31:0] rdat;
        logic        stop_dis;
        logic        ext_clk;
        logic        stop_done;
        logic        wait_done;
        logic        bus_fix;
        logic        wait_cstop;
        logic        pll_en;
        logic        sys_sel;
        logic [1:0]  exit_src;
        logic [2:0]  sync;
        logic        byte_bus;
        logic [6:0]  div;
        logic        exit_prev;
        logic        osc_run;
        logic        osc_drv_off;
        logic        pll_run;
        logic        in_clk_en;
        logic        sys_clk_en;
        logic        peri_en;
        logic        wdiv_en;
        logic        bus_en;
        logic        div_hold;
        logic        adc_run;
        logic        wdt_run;
        logic        evt_only;
        logic        ser_ext;
        logic [6:0]  port_mux;
    } sb_state_t;

endpackage

// ===== tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.svh"

module tb;
    import standby_pkg::*;

    logic        clk_i;
    logic        rst_i;
    logic        cyc, stb, we, go_stop, go_wait, irq_req, byte_bus;
    logic [4:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, dat_o;
    logic        ack_o, stop_m, wait_m, irq_acc;
    logic        osc, off, pll, in_en, sys_en, peri, wdiv, bus_en, hold, adc, wdt, evt, ser;
    logic [6:0]  pmux;
    logic [12:0] outs;
    int          failures;
    int          n_compared;
    int          n;

    assign outs = {osc, off, pll, in_en, sys_en, peri, wdiv, bus_en, hold, adc, wdt, evt, ser};

    cpu_model i_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .go_stop_i(go_stop), .go_wait_i(go_wait),
        .irq_req_i(irq_req), .core_run_i(bus_en), .stop_mode_o(stop_m), .wait_mode_o(wait_m),
        .irq_accept_o(irq_acc));

    standby_ctrl i_standby_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
        .stop_mode_i(stop_m), .wait_mode_i(wait_m), .irq_accept_i(irq_acc), .byte_bus_i(byte_bus),
        .osc_run_o(osc), .osc_driver_off_o(off), .pll_run_o(pll), .input_clock_en_o(in_en),
        .sys_clock_en_o(sys_en), .peripheral_clocks_en_o(peri), .watchdog_div_en_o(wdiv),
        .bus_unit_clock_en_o(bus_en), .stop_exit_hold_o(hold), .adc_run_o(adc), .watchdog_run_o(wdt),
        .timer_event_only_o(evt), .serial_ext_only_o(ser), .port_mux_o(pmux));

    always #10 clk_i = ~clk_i;

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Values read right after an edge are the ones that edge sampled
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 50);
        rdat = dat_o;
        check(k < 50, 1'b1, "bus answer");
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        check(rdat, exp, what);
    endtask

    task automatic instr(input logic s);
        @(posedge clk_i);
        go_stop <= s;
        go_wait <= ~s;
        @(posedge clk_i);
        go_stop <= 1'b0;
        go_wait <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic wake(output int c);
        c = 0;
        @(posedge clk_i);
        irq_req <= 1'b1;
        do begin
            @(posedge clk_i);
            c++;
        end while (bus_en !== 1'b1 && c < 40000);
        check(c < 40000, 1'b1, "wake answer");
        irq_req <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic finish_test();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Watchdog: the stop wake delay alone is about 33k cycles
    // ----------------------------------------
    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        $display("wrong value at %0t: run did not complete", $time);
        finish_test();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {clk_i, cyc, stb, we, go_stop, go_wait, irq_req, byte_bus} = '0;
        {adr, sel, wdat, failures, n_compared} = '0;
        rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`OFS_FUNC0, 32'h0, "stop disable reset");
        rd(`OFS_CLKCTL, 32'h2, "pll enable reset");
        rd(5'h14, 32'h0, "unmapped read");
        check(outs, 13'h17EC, "run clocks");
        // Stop ignored while disabled, no flag
        wb(1'b1, `OFS_FUNC0, 32'h1);
        instr(1'b1);
        rd(`OFS_STATUS, 32'h0, "stop ignored");
        rd(`OFS_FUNC1, 32'h0, "no stop flag");
        wb(1'b1, `OFS_FUNC0, 32'h0);
        // Wait with system clock running and bus fixation
        wb(1'b1, `OFS_FUNC1, 32'h4);
        instr(1'b0);
        check(outs, 13'h1788, "wait clocks");
        check(pmux, 7'h7F, "fixation in wait");
        rd(`OFS_STATUS, 32'h6, "wait mode");
        wake(n);
        check(n <= 4, 1'b1, "wait exit prompt");
        check(outs, 13'h17EC, "clocks after wait");
        check(pmux, 7'h00, "fixation released");
        rd(`OFS_FUNC1, 32'h6, "wait flag");
        // Software clears the flag and sets clock stop just before wait
        wb(1'b1, `OFS_FUNC1, 32'h8);
        instr(1'b0);
        check(outs, 13'h1603, "wait clock stop");
        check(pmux, 7'h00, "no fixation");
        wake(n);
        check(n <= 4, 1'b1, "wait exit prompt");
        wb(1'b1, `OFS_FUNC1, 32'h0);
        check(outs, 13'h17EC, "clocks after wait");
        // Stop with internal clock: watchdog delay on divide by 16
        wb(1'b1, `OFS_WDTFS, 32'h0);
        instr(1'b1);
        check(outs, 13'h0013, "stop clocks");
        rd(`OFS_STATUS, 32'h000FFF01, "stop count loaded");
        wake(n);
        check(n >= 2047 * 16 && n <= 2049 * 16 + 8, 1'b1, "watchdog wake delay");
        check(outs, 13'h17EC, "clocks after stop");
        rd(`OFS_FUNC1, 32'h1, "stop flag");
        // Reset ends stop and restores the core clock at once
        instr(1'b1);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check(outs, 13'h17EC, "reset exit");
        // External clock, PLL off: wake on first divider fall, divide by 128
        wb(1'b1, `OFS_CLKCTL, 32'h0);
        wb(1'b1, `OFS_FUNC0, 32'h2);
        wb(1'b1, `OFS_WDTFS, 32'hC0);
        check(outs, 13'h0BEC, "external clock run");
        instr(1'b1);
        check(outs, 13'h0813, "external clock stop");
        wake(n);
        check(n >= 1 && n <= 140, 1'b1, "edge wake delay");
        check(outs, 13'h0BEC, "clocks after edge wake");
        // Byte-wide bus keeps upper data and high strobe on ports
        byte_bus <= 1'b1;
        repeat (6) @(posedge clk_i);
        check(pmux, 7'h24, "byte bus pins");
        // The edge wake never counts, so the count still holds its stop-entry load
        rd(`OFS_STATUS, 32'h000FFF08, "byte bus status");
        finish_test();
    end
endmodule // tb

`default_nettype wire

// ===== wake_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "standby_defines.svh"

module wake_timer
    import standby_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        load_i,
    input  wire logic        tick_i,
    input  wire logic        run_i,
    output logic [11:0]      count_o
);

    wake_state_t s;
    wake_state_t n;

    always_comb begin
        n = s;
        if (load_i) begin
            n.cnt = `WDT_LOAD;
        end else if (run_i && tick_i && s.cnt != 12'h000) begin
            n.cnt = s.cnt - 12'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= n;
        end
    end

    assign count_o = s.cnt;

    a_load_all_ones: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && load_i |=> count_o == 12'hFFF)
        else $error("wake count not loaded with all ones");

endmodule // wake_timer

`default_nettype wire
